// ### src/scf_consts.vh
// Constants for the single-clock FIFO with its APB register slave.
// Assumes one clock (pclk, 200 MHz) and an active-low asynchronous reset.
// Behaviour
// [RULE1] Writer and reader share one clock, and depth and data format are fixed by parameters.
// [RULE2] A write request on a clock edge stores the input word as the newest entry.
// [RULE3] A read request presents the oldest word on the output and removes it.
// [RULE4] The reader must not trust the output after reading an empty buffer.
// [RULE5] Full is high while every entry is occupied, and writes are then ignored.
// [RULE6] Empty is high while no entry is occupied, and reads are then ignored.
// [RULE7] A count output gives the number of stored words as unsigned.
// [RULE8] An enabled clear on a clock edge discards every word and leaves count zero.
// [RULE9] The clear input only acts when its option is turned on.
// [RULE10] The depth parameter defaults to 64 words.
// [RULE11] Format is inferred, signed integer, signed fractional or unsigned; fraction bits only for fractional; code adds R1 in every format.
// [RULE12] Data in and data out are integer plus fraction bits wide.
// [RULE13] For the signed formats the top bit of each word is the sign.
// [RULE14] A show-ahead read mode can be chosen instead of the normal mode.
// [RULE15] Show-ahead shows the oldest word while not empty; normal mode shows it one clock after the request.
// [RULE16] A write and read accepted together keep the count and the order.
// [RULE17] The count is wide enough for every value from zero to the depth.
`ifndef SCF_CONSTS_VH
`define SCF_CONSTS_VH

// Register byte addresses
`define SCF_ADDR_CTRL    12'h000
`define SCF_ADDR_STATUS  12'h004
`define SCF_ADDR_COUNT   12'h008
`define SCF_ADDR_IRQ_ST  12'h00C
`define SCF_ADDR_IRQ_MSK 12'h010
`define SCF_ADDR_FORMAT  12'h014

// Control fields
`define SCF_CTRL_CLR_BIT    0
`define SCF_CTRL_RESET      32'h0000_0000

// Status and interrupt fields
`define SCF_ST_EMPTY_BIT    0
`define SCF_ST_FULL_BIT     1
`define SCF_ST_SIGN_BIT     2
`define SCF_IRQ_OVF_BIT     0
`define SCF_IRQ_UNF_BIT     1
`define SCF_IRQ_FULL_BIT    2
`define SCF_IRQ_WIDTH       3
`define SCF_IRQ_MSK_RESET   3'h0

// Data formats
`define SCF_FMT_INFERRED    2'h0
`define SCF_FMT_SINT        2'h1
`define SCF_FMT_SFRAC       2'h2
`define SCF_FMT_UINT        2'h3

`endif

// ### src/scf_store.v
// Word store of the FIFO: register array with pointers and count.
// Assumes the caller gates requests with full and empty already.
`timescale 1ns/1ps
module scf_store #(
    parameter DEPTH = 64,
    parameter WIDTH = 16,
    parameter AW    = 6,
    parameter CW    = 7
) (
    // Clock and reset
    input  wire             pclk,
    input  wire             presetn,
    // Control
    input  wire             clr,
    input  wire             push,
    input  wire             pop,
    input  wire [WIDTH-1:0] wdata,
    // State
    output wire [WIDTH-1:0] head,
    output wire [WIDTH-1:0] head2,
    output reg  [CW-1:0]    count
);

    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW-1:0]    wr_ptr;
    reg [AW-1:0]    rd_ptr;

    // Wrap an index at the depth, which need not be a power of two
    function [AW-1:0] bump;
        input [AW-1:0] p;
        begin
            if (p == DEPTH[AW-1:0] - 1'b1) begin
                bump = {AW{1'b0}};
            end else begin
                bump = p + 1'b1;
            end
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // [RULE2] store newest word
    always @(posedge pclk) begin
        if (push) begin
            mem[wr_ptr] <= wdata;
        end
    end

    assign head = mem[rd_ptr];

    // Second-oldest word, so show-ahead can reload its output register on a pop
    assign head2 = mem[bump(rd_ptr)];

    // Pointers and count
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wr_ptr <= {AW{1'b0}};
            rd_ptr <= {AW{1'b0}};
            count  <= {CW{1'b0}};
        // [RULE8] clear drops all
        end else if (clr) begin
            wr_ptr <= {AW{1'b0}};
            rd_ptr <= {AW{1'b0}};
            count  <= {CW{1'b0}};
        end else begin
            if (push) begin
                wr_ptr <= bump(wr_ptr);
            end
            // [RULE3] remove oldest word
            if (pop) begin
                rd_ptr <= bump(rd_ptr);
            end
            // [RULE16] both keep count
            if (push && !pop) begin
                count <= count + 1'b1;
            end else if (pop && !push) begin
                count <= count - 1'b1;
            end
        end
    end

endmodule // scf_store

// ### src/scf_fifo.v
// Single-clock FIFO with APB status, control and interrupt registers.
// Assumes writer and reader logic run on pclk and drive requests synchronously.
`timescale 1ns/1ps
`include "scf_consts.vh"
module scf_fifo #(
    // [RULE10] default 64 words
    parameter       DEPTH      = 64,
    parameter       L1         = 16,
    parameter       R1         = 0,
    parameter [1:0] FORMAT     = `SCF_FMT_INFERRED,
    parameter       USE_SCLR   = 1,
    parameter       SHOW_AHEAD = 0
) (
    // Clock and reset
    input  wire              pclk,
    input  wire              presetn,
    // Writer side
    input  wire [L1+R1-1:0]  wr_data,
    input  wire              wr_req,
    // Reader side
    input  wire              rd_req,
    output reg  [L1+R1-1:0]  rd_data,
    // Clear and status
    input  wire              sync_clr,
    output wire              full,
    output wire              empty,
    output wire [$clog2(DEPTH+1)-1:0] used_words,
    output wire              rd_sign,
    // APB slave
    input  wire              psel,
    input  wire              penable,
    input  wire              pwrite,
    input  wire [11:0]       paddr,
    input  wire [31:0]       pwdata,
    output reg  [31:0]       prdata,
    output wire              pready,
    output wire              pslverr,
    // Interrupt
    output wire              irq
);

    // [RULE17] count spans 0..DEPTH
    localparam L2    = $clog2(DEPTH + 1);
    localparam AW    = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    // [RULE12] integer plus fraction bits
    localparam WIDTH = L1 + R1;
    // [RULE11] fraction only for fractional, but WIDTH adds R1 in every format
    localparam SIGNED_FMT = (FORMAT == `SCF_FMT_SINT) || (FORMAT == `SCF_FMT_SFRAC);

    reg  [31:0]               ctrl;
    reg  [`SCF_IRQ_WIDTH-1:0] irq_st;
    reg  [`SCF_IRQ_WIDTH-1:0] irq_msk;
    wire [WIDTH-1:0]          head;
    wire [WIDTH-1:0]          head2;
    wire                      clr;
    wire                      push;
    wire                      pop;
    wire                      apb_wr;
    wire                      apb_rd;
    wire                      ovf_evt;
    wire                      unf_evt;
    wire                      full_evt;
    reg                       full_q;

    ////////////////////////////////////////////////////////////////////////
    // Request gating

    // [RULE9] clear only if enabled
    assign clr  = (USE_SCLR != 0) && (sync_clr || ctrl[`SCF_CTRL_CLR_BIT]);
    // [RULE5] ignore write when full
    assign push = wr_req && !full && !clr;
    // [RULE6] ignore read when empty
    assign pop  = rd_req && !empty && !clr;

    // [RULE1] one clock store
    // [RULE7] count of held words
    scf_store #(
        .DEPTH (DEPTH),
        .WIDTH (WIDTH),
        .AW    (AW),
        .CW    (L2)
    ) u_store (
        .pclk    (pclk),
        .presetn (presetn),
        .clr     (clr),
        .push    (push),
        .pop     (pop),
        .wdata   (wr_data),
        .head    (head),
        .head2   (head2),
        .count   (used_words)
    );

    // [RULE5] full flag
    assign full  = (used_words == DEPTH[L2-1:0]);
    // [RULE6] empty flag
    assign empty = (used_words == {L2{1'b0}});

    ////////////////////////////////////////////////////////////////////////
    // Read data path

    // [RULE14] read mode by parameter
    generate
        if (SHOW_AHEAD != 0) begin : g_show
            // [RULE15] oldest visible early
            // Registered copy of the head: next oldest word one clock after a pop.
            // Bypass when empty so the first write shows up on the same edge that stores it.
            always @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    rd_data <= {WIDTH{1'b0}};
                end else if (clr) begin
                    rd_data <= {WIDTH{1'b0}};
                end else if (push && (empty || (pop && used_words == 1))) begin
                    rd_data <= wr_data;
                end else if (pop) begin
                    rd_data <= head2;
                end else if (!empty) begin
                    rd_data <= head;
                end
            end
        end else begin : g_norm
            // [RULE15] word one clock later
            // [RULE4] empty read holds old value
            always @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    rd_data <= {WIDTH{1'b0}};
                end else if (pop) begin
                    rd_data <= head;
                end
            end
        end
    endgenerate

    // [RULE13] top bit is sign
    assign rd_sign = SIGNED_FMT ? rd_data[WIDTH-1] : 1'b0;

    ////////////////////////////////////////////////////////////////////////
    // Interrupt events

    assign ovf_evt  = wr_req && full && !clr;
    assign unf_evt  = rd_req && empty && !clr;
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            full_q <= 1'b0;
        end else begin
            full_q <= full;
        end
    end
    assign full_evt = full && !full_q;

    ////////////////////////////////////////////////////////////////////////
    // APB slave: zero wait states, unmapped reads give zero

    assign apb_wr  = psel && penable && pwrite;
    assign apb_rd  = psel && penable && !pwrite;
    assign pready  = 1'b1;
    assign pslverr = 1'b0;

    // Control register; clear bit is self-clearing
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl <= `SCF_CTRL_RESET;
        end else if (apb_wr && paddr == `SCF_ADDR_CTRL) begin
            ctrl <= pwdata;
        end else begin
            ctrl[`SCF_CTRL_CLR_BIT] <= 1'b0;
        end
    end

    // Mask register
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_msk <= `SCF_IRQ_MSK_RESET;
        end else if (apb_wr && paddr == `SCF_ADDR_IRQ_MSK) begin
            irq_msk <= pwdata[`SCF_IRQ_WIDTH-1:0];
        end
    end

    // Sticky status, cleared by reading; a new event wins over the clear.
    // Only bits already latched into prdata at setup are cleared, so an event
    // landing between setup and access stays pending instead of being lost.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_st <= {`SCF_IRQ_WIDTH{1'b0}};
        end else begin
            irq_st <= (irq_st & ~((apb_rd && paddr == `SCF_ADDR_IRQ_ST) ?
                                  prdata[`SCF_IRQ_WIDTH-1:0] :
                                  {`SCF_IRQ_WIDTH{1'b0}})) |
                      {full_evt, unf_evt, ovf_evt};
        end
    end

    assign irq = |(irq_st & irq_msk);

    // Read mux, registered so data is steady during the access phase
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (psel && !penable && !pwrite) begin
            case (paddr)
                `SCF_ADDR_CTRL:    prdata <= ctrl;
                `SCF_ADDR_STATUS:  prdata <= {29'h0, rd_sign, full, empty};
                `SCF_ADDR_COUNT:   prdata <= {{(32-L2){1'b0}}, used_words};
                `SCF_ADDR_IRQ_ST:  prdata <= {29'h0, irq_st};
                `SCF_ADDR_IRQ_MSK: prdata <= {29'h0, irq_msk};
                `SCF_ADDR_FORMAT:  prdata <= {30'h0, FORMAT};
                default:           prdata <= 32'h0000_0000;
            endcase
        end
    end

endmodule // scf_fifo

// ### sim/scf_fifo_assertions.sv
// Concurrent checks on the FIFO top-level ports.
// Assumes a bind onto scf_fifo with its parameters handed on.
`timescale 1ns/1ps
`include "scf_consts.vh"
module scf_fifo_chk #(
    parameter       DEPTH  = 64,
    parameter       L1     = 16,
    parameter       R1     = 0,
    parameter [1:0] FORMAT = 2'h0
) (
    // Clock and reset
    input wire                    pclk,
    input wire                    presetn,
    // Datapath
    input wire                    wr_req,
    input wire                    rd_req,
    input wire                    sync_clr,
    input wire                    full,
    input wire                    empty,
    input wire [$clog2(DEPTH+1)-1:0] used_words,
    input wire [L1+R1-1:0]        rd_data,
    input wire                    rd_sign
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // Accepted requests; clear wins over both
    sequence s_put; wr_req && !full && !rd_req && !sync_clr; endsequence
    sequence s_take; rd_req && !empty && !wr_req && !sync_clr; endsequence
    sequence s_both; wr_req && rd_req && !full && !empty && !sync_clr; endsequence
    chk_write_count: assert property (s_put |=> used_words == $past(used_words) + 1'b1)
        else $error("count did not rise on write");
    chk_read_count: assert property (s_take |=> used_words == $past(used_words) - 1'b1)
        else $error("count did not fall on read");
    chk_both_keep: assert property (s_both |=> $stable(used_words))
        else $error("count moved on write with read");
    chk_clear_empty: assert property (sync_clr |=> empty && used_words == 0)
        else $error("clear left words behind");
    chk_full_refuse: assert property (full && !rd_req && !sync_clr |=> full && $stable(used_words))
        else $error("write accepted while full");
    chk_empty_refuse: assert property (empty && !wr_req && !sync_clr |=> empty && $stable(used_words))
        else $error("read accepted while empty");
    chk_flag_levels: assert property (full == (used_words == DEPTH) && empty == (used_words == 0))
        else $error("flags disagree with count");
    chk_sign_bit: assert property (rd_sign == ((FORMAT == `SCF_FMT_SINT || FORMAT == `SCF_FMT_SFRAC) ? rd_data[L1+R1-1] : 1'b0))
        else $error("sign output wrong");
endmodule // scf_fifo_chk

// ### sim/scf_peer.sv
// Writer and reader logic on the far side of the FIFO datapath.
// Assumes the bench calls xfer once per operation, on pclk.
`timescale 1ns/1ps
module scf_peer #(
    parameter W = 8
) (
    // Clock
    input  wire          pclk,
    // Toward the FIFO, plus rd_ok for the bench
    output logic         wr_req,
    output logic [W-1:0] wr_data,
    output logic         rd_req,
    output logic         rd_ok,
    // From the FIFO
    input  wire          empty
);
    initial begin
        wr_req = 1'b0;
        rd_req = 1'b0;
        rd_ok = 1'b0;
        wr_data = {W{1'b0}};
    end
    // One request cycle, then release; idle data flips so stale words never match
    task automatic xfer(input logic w, input logic [W-1:0] d, input logic r);
        @(posedge pclk);
        wr_req  <= w;
        wr_data <= d;
        rd_req  <= r;
        @(posedge pclk);
        rd_ok   <= r && !empty;
        wr_req  <= 1'b0;
        rd_req  <= 1'b0;
        wr_data <= ~d;
    endtask
endmodule // scf_peer

// ### sim/scf_fifo_test.sv
// Self-checking bench for the FIFO with its register slave.
// Assumes the peer model and checker files are compiled first.
`timescale 1ns/1ps
`include "scf_consts.vh"
module scf_fifo_test;
    localparam DEPTH = 8;
    logic        pclk, presetn, rd_req, wr_req, sync_clr, rd_ok;
    logic        full, empty, rd_sign, psel, penable, pwrite, pready, pslverr, irq;
    logic [7:0]  wr_data, rd_data, rd_data_sa;
    logic [3:0]  used_words;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, q;
    int          errors, checks, i;
    scf_fifo #(.DEPTH(DEPTH), .L1(8), .R1(0), .FORMAT(`SCF_FMT_SINT)) u_dut (
        .pclk(pclk), .presetn(presetn), .wr_data(wr_data), .wr_req(wr_req),
        .rd_req(rd_req), .rd_data(rd_data), .sync_clr(sync_clr), .full(full),
        .empty(empty), .used_words(used_words), .rd_sign(rd_sign), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq));
    // Show-ahead twin fed by the same writer, reader and bus
    scf_fifo #(.DEPTH(DEPTH), .L1(8), .R1(0), .FORMAT(`SCF_FMT_SINT), .SHOW_AHEAD(1)) u_dut_sa (
        .pclk(pclk), .presetn(presetn), .wr_data(wr_data), .wr_req(wr_req),
        .rd_req(rd_req), .rd_data(rd_data_sa), .sync_clr(sync_clr), .full(),
        .empty(), .used_words(), .rd_sign(), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(), .pready(), .pslverr(), .irq());
    scf_peer #(.W(8)) u_peer (.pclk(pclk), .wr_req(wr_req), .wr_data(wr_data),
        .rd_req(rd_req), .rd_ok(rd_ok), .empty(empty));
    ////////////////////////////////////////////////////////////////////////
    // Tasks
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            errors++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask
    // APB cycle; waits on pready rather than assuming a latency
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        q = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    function automatic logic [7:0] pat(input int n);
        return 8'(8'h5A + n * 8'h93);
    endfunction
    task automatic wrap_up();
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////
    // Clock and watchdog
    initial begin
        pclk = 1'b0;
        forever #2.5 pclk = ~pclk;
    end
    initial begin
        #100000;
        errors++;
        wrap_up();
    end
    // Main sequence
    initial begin
        {presetn, sync_clr, psel, penable, pwrite, paddr, pwdata} = '0;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        check("empty", 1, empty);
        apb(0, `SCF_ADDR_IRQ_MSK, 0);
        check("mask", 0, q);
        apb(0, `SCF_ADDR_FORMAT, 0);
        check("format", `SCF_FMT_SINT, q);
        apb(0, 12'h0FC, 0);
        check("unmapped", 0, q);
        apb(1, `SCF_ADDR_IRQ_MSK, 32'h1);
        for (i = 0; i < DEPTH; i++) u_peer.xfer(1, pat(i), 0);
        u_peer.xfer(1, 8'h00, 0);
        #1 check("count full", DEPTH, used_words);
        check("irq", 1, irq);
        check("full flag", 1, full);
        apb(0, `SCF_ADDR_STATUS, 0);
        check("status full", 32'h2, q);
        apb(0, `SCF_ADDR_COUNT, 0);
        check("count reg", DEPTH, q);
        check("slave error", 0, pslverr);
        apb(0, `SCF_ADDR_IRQ_ST, 0);
        check("overflow", 1, q & 1);
        #1 check("irq cleared", 0, irq);
        for (i = 0; i < DEPTH; i++) begin
            check("ahead", pat(i), rd_data_sa);
            u_peer.xfer(0, 8'h00, 1);
            #1 check("order", pat(i), rd_data);
            check("sign", pat(i) >> 7, rd_sign);
        end
        u_peer.xfer(0, 8'h00, 1);
        #1 check("empty read", 0, rd_ok);
        check("empty count", 0, used_words);
        check("still empty", 1, empty);
        u_peer.xfer(1, 8'h3C, 0);
        u_peer.xfer(1, 8'hC3, 1);
        #1 check("same edge", 8'h3C, rd_data);
        check("same count", 1, used_words);
        check("ahead same edge", 8'hC3, rd_data_sa);
        sync_clr <= 1'b1;
        @(posedge pclk);
        sync_clr <= 1'b0;
        #1 check("clear", 0, used_words);
        u_peer.xfer(1, 8'h11, 0);
        apb(1, `SCF_ADDR_CTRL, 32'h1);
        #1 check("soft clear", 1, empty);
        apb(0, `SCF_ADDR_CTRL, 0);
        check("ctrl self clear", 0, q);
        wrap_up();
    end
endmodule // scf_fifo_test
bind scf_fifo scf_fifo_chk #(.DEPTH(DEPTH), .L1(L1), .R1(R1), .FORMAT(FORMAT)) u_chk (
    .pclk(pclk), .presetn(presetn), .wr_req(wr_req), .rd_req(rd_req), .sync_clr(sync_clr),
    .full(full), .empty(empty), .used_words(used_words), .rd_data(rd_data), .rd_sign(rd_sign));
